// File: core/tcu8_defs.svh
// constants of the 8-bit timer with one compare channel
// assumes inclusion by bare name from the design file
`ifndef TCU8_DEFS_SVH
`define TCU8_DEFS_SVH

// count range limits
`define TCU8_BOTTOM      8'h00
`define TCU8_MAX         8'hFF
// waveform modes
`define TCU8_WGM_NORMAL  2'h0
`define TCU8_WGM_PCPWM   2'h1
`define TCU8_WGM_CTC     2'h2
`define TCU8_WGM_FAST    2'h3
// output actions
`define TCU8_COM_NONE    2'h0
`define TCU8_COM_TOGGLE  2'h1
`define TCU8_COM_CLEAR   2'h2
`define TCU8_COM_SET     2'h3
// clock select value for a stopped timer
`define TCU8_CS_STOP     3'h0
// reset values
`define TCU8_RST_BYTE    8'h00

`endif

// File: core/tcu8_pkg.sv
// types shared by the 8-bit compare timer
// assumes tcu8_defs.svh on the include path
`default_nettype none

package tcu8_pkg;
  // control fields written by software
  typedef struct packed {
    logic [2:0] clockSelect;   // clock_select_field
    logic [1:0] waveMode;      // waveform_mode_field
    logic [1:0] outAction;     // output_action_field
    logic       asyncSelect;   // async_clock_select
    logic       irqEnable;     // compare_irq_enable
    logic       ovfIrqEnable;  // overflow enable in mask reg
  } tcu8_ctrl_t;

  // sticky flags seen by software
  typedef struct packed {
    logic compareMatch;        // compare_match_flag
    logic overflow;            // overflow_flag
  } tcu8_flags_t;

  // counter sequencing states
  typedef enum logic [1:0] {
    TCU8_UP   = 2'b01,
    TCU8_DOWN = 2'b10
  } tcu8_dir_t;
endpackage

`default_nettype wire

// File: core/tcu8_timer.sv
// 8-bit timer/counter with one output compare channel
// assumes a prescaler outside gives tickIo enables on mclk and tickXtal as a crystal level
`timescale 1ns/1ps
`include "tcu8_defs.svh"
`default_nettype none

module tcu8_timer (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire tcu8_pkg::tcu8_ctrl_t ctrl,
  input  wire logic              tickIo,
  input  wire logic              tickXtal,
  input  wire logic              countWrite,
  input  wire logic [7:0]        countWdata,
  input  wire logic              compareWrite,
  input  wire logic [7:0]        compareWdata,
  input  wire logic              forceCompare,
  input  wire logic [1:0]        flagClearWrite,
  input  wire logic              compareIrqAck,
  input  wire logic              overflowIrqAck,
  output logic [7:0]             timerCountValue,
  output logic [7:0]             compareValueReg,
  output tcu8_pkg::tcu8_flags_t  timerFlags,
  output logic                   compareIrq,
  output logic                   overflowIrq,
  output logic                   compareOutput,
  output logic                   atBottom,
  output logic                   atMax
);

  // ==========================================================
  // state
  // ==========================================================
  logic [7:0] count_reg;            // live counter
  logic [7:0] count_next;           // counter next value
  logic [7:0] ocr_reg;              // live compare value
  logic [7:0] ocrBuf_reg;           // compare buffer
  logic       oc_reg;               // compare output register
  logic       block_reg;            // match blocked for next tick
  logic       cmpFlag_reg;          // compare match flag
  logic       ovfFlag_reg;          // overflow flag
  tcu8_pkg::tcu8_dir_t dir_reg;     // count direction
  logic [2:0] xtalSync_reg;         // crystal tick synchroniser
  logic       xtalEdge_reg;         // last agreed crystal level
  logic       tick;                 // timer tick this cycle
  logic       xtalTick;             // synchronised crystal tick
  logic       match;                // comparator equality
  logic       matchEvent;           // unblocked match on a tick
  logic       isPwm;                // pwm mode active
  logic [7:0] topValue;             // top of count sequence
  logic       atTop;                // counter at top
  logic       ovfEvent;             // overflow condition this tick

  // ==========================================================
  // range indications
  // ==========================================================
  assign atBottom = (count_reg == `TCU8_BOTTOM);
  assign atMax    = (count_reg == `TCU8_MAX);
  assign isPwm    = ctrl.waveMode[0];
  // ctc uses compare value as top, others fixed max
  assign topValue = (ctrl.waveMode == `TCU8_WGM_CTC) ?
                    ocr_reg : `TCU8_MAX;
  assign atTop    = (count_reg == topValue);

  // ==========================================================
  // clock source
  // ==========================================================
  // three stage synchroniser, edge when stages 2 and 3 agree
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      xtalSync_reg <= 3'h0;
      xtalEdge_reg <= 1'b0;
    end else begin
      xtalSync_reg <= {xtalSync_reg[1:0], tickXtal};
      if (xtalSync_reg[2] == xtalSync_reg[1]) begin
        xtalEdge_reg <= xtalSync_reg[2];
      end
    end
  end
  // rising edge of the agreed crystal level
  assign xtalTick = (xtalSync_reg[2] == xtalSync_reg[1]) &&
                    xtalSync_reg[2] && !xtalEdge_reg;
  // source mux, stopped when select is zero
  assign tick = (ctrl.clockSelect != `TCU8_CS_STOP) &&
                (ctrl.asyncSelect ? xtalTick : tickIo);

  // ==========================================================
  // comparator
  // ==========================================================
  assign match      = (count_reg == ocr_reg);
  assign matchEvent = tick && match && !block_reg;

  // overflow per mode
  always_comb begin
    ovfEvent = 1'b0;
    case (ctrl.waveMode)
      `TCU8_WGM_NORMAL: ovfEvent = tick && atMax;
      `TCU8_WGM_CTC:    ovfEvent = tick && atMax;
      `TCU8_WGM_FAST:   ovfEvent = tick && atMax;
      default:          ovfEvent = tick && atBottom &&
                                   (dir_reg == tcu8_pkg::TCU8_DOWN);
    endcase
  end

  // ==========================================================
  // counter
  // ==========================================================
  always_comb begin
    count_next = count_reg;
    if (countWrite) begin
      count_next = countWdata;
    end else if (tick) begin
      case (ctrl.waveMode)
        `TCU8_WGM_CTC: begin
          // clear on match, else up
          count_next = matchEvent ? `TCU8_BOTTOM :
                       8'(count_reg + 8'h01);
        end
        `TCU8_WGM_PCPWM: begin
          // dual slope, bi-directional count
          if (dir_reg == tcu8_pkg::TCU8_UP) begin
            count_next = 8'(count_reg + 8'h01);
          end else begin
            count_next = 8'(count_reg - 8'h01);
          end
        end
        default: begin
          // normal and fast pwm wrap from max
          count_next = 8'(count_reg + 8'h01);
        end
      endcase
    end
  end

  // counter register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_reg <= `TCU8_RST_BYTE;
    end else begin
      count_reg <= count_next;
    end
  end

  // direction for the dual slope mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dir_reg <= tcu8_pkg::TCU8_UP;
    end else if (ctrl.waveMode != `TCU8_WGM_PCPWM) begin
      dir_reg <= tcu8_pkg::TCU8_UP;
    end else if (tick) begin
      if (count_next == `TCU8_MAX) begin
        dir_reg <= tcu8_pkg::TCU8_DOWN;
      end else if (count_next == `TCU8_BOTTOM) begin
        dir_reg <= tcu8_pkg::TCU8_UP;
      end
    end
  end

  // block flag: set by any counter write, cleared by a tick
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      block_reg <= 1'b0;
    end else if (countWrite) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // ==========================================================
  // compare value and buffer
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ocrBuf_reg <= `TCU8_RST_BYTE;
    end else if (compareWrite) begin
      ocrBuf_reg <= compareWdata;
    end
  end

  // live register: direct when unbuffered, loaded at max in both pwm modes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ocr_reg <= `TCU8_RST_BYTE;
    end else if (!isPwm) begin
      if (compareWrite) begin
        ocr_reg <= compareWdata;
      end
    end else if (tick && ((ctrl.waveMode == `TCU8_WGM_FAST &&
                 atMax) || (ctrl.waveMode == `TCU8_WGM_PCPWM &&
                 atMax))) begin
      ocr_reg <= ocrBuf_reg;
    end
  end

  // ==========================================================
  // flags and requests
  // ==========================================================
  // hardware set wins over clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmpFlag_reg <= 1'b0;
    end else if (matchEvent) begin
      cmpFlag_reg <= 1'b1;
    end else if (flagClearWrite[1] || compareIrqAck) begin
      cmpFlag_reg <= 1'b0;
    end
  end

  // overflow flag
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ovfFlag_reg <= 1'b0;
    end else if (ovfEvent) begin
      ovfFlag_reg <= 1'b1;
    end else if (flagClearWrite[0] || overflowIrqAck) begin
      ovfFlag_reg <= 1'b0;
    end
  end

  assign compareIrq  = cmpFlag_reg && ctrl.irqEnable;
  assign overflowIrq = ovfFlag_reg && ctrl.ovfIrqEnable;

  // ==========================================================
  // waveform generator
  // ==========================================================
  // action field used live, register kept across mode changes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      oc_reg <= 1'b0;
    end else if (ctrl.waveMode == `TCU8_WGM_FAST) begin
      if (matchEvent && ctrl.outAction[1]) begin
        oc_reg <= ctrl.outAction[0];
      end else if (tick && atMax && ctrl.outAction[1]) begin
        oc_reg <= !ctrl.outAction[0];
      end
    end else if (ctrl.waveMode == `TCU8_WGM_PCPWM) begin
      if (matchEvent && ctrl.outAction[1]) begin
        oc_reg <= (dir_reg == tcu8_pkg::TCU8_UP) ^
                  !ctrl.outAction[0];
      end
    end else if (matchEvent || forceCompare) begin
      case (ctrl.outAction)
        `TCU8_COM_TOGGLE: oc_reg <= !oc_reg;
        `TCU8_COM_CLEAR:  oc_reg <= 1'b0;
        `TCU8_COM_SET:    oc_reg <= 1'b1;
        default:          oc_reg <= oc_reg;
      endcase
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign timerCountValue = count_reg;
  assign compareValueReg = isPwm ? ocrBuf_reg : ocr_reg;
  assign timerFlags      = '{compareMatch: cmpFlag_reg,
                             overflow:     ovfFlag_reg};
  assign compareOutput   = oc_reg;

  // ==========================================================
  // checks
  // ==========================================================
  // counter and range
  AST_BOTTOM: assert property (@(posedge mclk) disable iff (!reset_n)
    (tick && atMax && !countWrite && ctrl.waveMode == `TCU8_WGM_NORMAL)
    |=> atBottom)
    else $error("wrap did not reach bottom");
  AST_MAX: assert property (@(posedge mclk) disable iff (!reset_n)
    (tick && atMax && !countWrite && ctrl.waveMode == `TCU8_WGM_NORMAL)
    |=> ovfFlag_reg)
    else $error("max did not raise overflow");
  AST_STOP: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl.clockSelect == `TCU8_CS_STOP && !countWrite)
    |=> $stable(count_reg))
    else $error("stopped counter moved");
  AST_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    countWrite |=> (count_reg == $past(countWdata)))
    else $error("counter write lost");
  AST_STEP: assert property (@(posedge mclk) disable iff (!reset_n)
    (tick && !countWrite && ctrl.waveMode == `TCU8_WGM_NORMAL)
    |=> (count_reg == 8'($past(count_reg) + 8'h01)))
    else $error("counter did not step by one");
  AST_CTC: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl.waveMode == `TCU8_WGM_CTC && matchEvent && !countWrite)
    |=> atBottom)
    else $error("ctc match did not clear counter");
  // match flag and request
  AST_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
    (tick && match && !block_reg) |=> cmpFlag_reg)
    else $error("match flag not set");
  AST_BLOCK: assert property (@(posedge mclk) disable iff (!reset_n)
    (tick && match && block_reg && !flagClearWrite[1] && !compareIrqAck
     && !cmpFlag_reg) |=> !cmpFlag_reg)
    else $error("blocked match set flag");
  AST_CLR: assert property (@(posedge mclk) disable iff (!reset_n)
    (flagClearWrite[1] && !matchEvent) |=> !cmpFlag_reg)
    else $error("flag not cleared");
  AST_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
    (compareIrqAck && !matchEvent) |=> !cmpFlag_reg)
    else $error("serviced request not cleared");
  AST_FORCE: assert property (@(posedge mclk) disable iff (!reset_n)
    (forceCompare && !matchEvent && !cmpFlag_reg
     && ctrl.waveMode == `TCU8_WGM_NORMAL) |=> !cmpFlag_reg)
    else $error("force set flag");
  // compare buffer and output register
  AST_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    (isPwm && !(tick && atMax)) |=> $stable(ocr_reg))
    else $error("buffered compare changed off top");
  AST_KEEP: assert property (@(posedge mclk) disable iff (!reset_n)
    (!tick && !forceCompare) |=> $stable(oc_reg))
    else $error("output changed without event");
  COV_CTC: cover property (@(posedge mclk)
    ctrl.waveMode == `TCU8_WGM_CTC && matchEvent);
  COV_WRAP: cover property (@(posedge mclk) ovfEvent);
  COV_FORCE: cover property (@(posedge mclk) forceCompare);
  COV_BLOCKED: cover property (@(posedge mclk)
    tick && match && block_reg);
  COV_FAST: cover property (@(posedge mclk)
    ctrl.waveMode == `TCU8_WGM_FAST && matchEvent);

endmodule
`default_nettype wire

// File: testbench/tcu8_tick_model.sv
// tick source model: io prescaler enable and a watch crystal level
// assumes the bench asks for each io tick with a one-cycle request
`timescale 1ns/1ps
`default_nettype none

module tcu8_tick_model (
  input  wire logic ioReq,
  input  wire logic xtalKick,
  output logic      tickIo,
  output logic      tickXtal
);
  // ==========================================
  // io tick passes the prescaler request on
  assign tickIo = ioReq;

  // ==========================================
  // crystal: one slow high phase per kick, off mclk phase
  initial begin
    tickXtal = 1'b0;
  end
  always @(posedge xtalKick) begin
    #17 tickXtal = 1'b1;
    #190 tickXtal = 1'b0;
  end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench of the 8-bit compare timer
// assumes tcu8_pkg compiled first and the tick model beside it
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ==========================================
  // signals
  typedef struct {
    int         sel;   // which output
    logic [7:0] exp;   // expected value
  } tcu8_note_t;
  logic                  mclk = 1'b0;
  logic                  reset_n = 1'b0;
  tcu8_pkg::tcu8_ctrl_t  ctrl = '0;
  logic [7:0]            strb = 8'h00;  // one bit per strobe
  logic [7:0]            wdata = 8'h00;
  logic                  xtalKick = 1'b0;
  logic                  tickIo;
  logic                  tickXtal;
  logic [7:0]            cnt;
  logic [7:0]            cmp;
  tcu8_pkg::tcu8_flags_t flg;
  logic                  cIrq;
  logic                  oIrq;
  logic                  oc;
  logic                  bot;
  logic                  mx;
  tcu8_note_t            notes[$];
  int                    err_total = 0;
  int                    comparisons = 0;
  int                    cycles = 0;
  logic [7:0]            v;
  logic [1:0]            act[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic [7:0]            ocExp[4] = '{8'h01, 8'h00, 8'h01, 8'h01};

  // ==========================================
  // clock, timeout
  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      summarize();
    end
  end

  tcu8_tick_model tcu8_tick_model_i (
    .ioReq    (strb[0]),
    .xtalKick (xtalKick),
    .tickIo   (tickIo),
    .tickXtal (tickXtal)
  );

  tcu8_timer tcu8_timer_i (
    .mclk            (mclk),
    .reset_n         (reset_n),
    .ctrl            (ctrl),
    .tickIo          (tickIo),
    .tickXtal        (tickXtal),
    .countWrite      (strb[1]),
    .countWdata      (wdata),
    .compareWrite    (strb[2]),
    .compareWdata    (wdata),
    .forceCompare    (strb[3]),
    .flagClearWrite  (strb[5:4]),
    .compareIrqAck   (strb[6]),
    .overflowIrqAck  (strb[7]),
    .timerCountValue (cnt),
    .compareValueReg (cmp),
    .timerFlags      (flg),
    .compareIrq      (cIrq),
    .overflowIrq     (oIrq),
    .compareOutput   (oc),
    .atBottom        (bot),
    .atMax           (mx)
  );

  // ==========================================
  // tasks
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic note(input int sel, input logic [7:0] exp);
    notes.push_back('{sel, exp});
  endtask
  // one strobe cycle, then release
  task automatic op(input logic [7:0] m, input logic [7:0] d);
    @(posedge mclk);
    strb  <= m;
    wdata <= d;
    @(posedge mclk);
    strb  <= 8'h00;
  endtask
  task automatic setc(input tcu8_pkg::tcu8_ctrl_t c);
    @(posedge mclk);
    ctrl <= c;
    @(posedge mclk);
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // monitor: all pending notes, oldest first, against settled outputs
  always @(negedge mclk) begin
    tcu8_note_t n;
    logic [7:0] s;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: s = cnt;
        1: s = cmp;
        2: s = {6'h00, flg};
        3: s = {7'h00, cIrq};
        4: s = {7'h00, oIrq};
        5: s = {7'h00, oc};
        6: s = {7'h00, bot};
        default: s = {7'h00, mx};
      endcase
      check($sformatf("out%0d", n.sel), s, n.exp);
    end
  end

  // ==========================================
  // stimulus
  initial begin
    void'($urandom(43));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    note(0, 8'h00); note(6, 8'h01); note(2, 8'h00); note(5, 8'h00);
    op(8'h01, 8'h00);
    note(0, 8'h00);
    setc('{3'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1});
    op(8'h02, 8'hFE);
    note(0, 8'hFE);
    op(8'h01, 8'h00);
    note(0, 8'hFF); note(7, 8'h01);
    op(8'h01, 8'h00);
    note(0, 8'h00); note(2, 8'h01); note(4, 8'h01);
    op(8'h80, 8'h00);
    note(2, 8'h00);
    op(8'h03, 8'h40);
    note(0, 8'h40);
    note(2, 8'h02); note(3, 8'h00);
    op(8'h20, 8'h00);
    note(2, 8'h00);
    v = 8'($urandom_range(32'hE0, 32'h10));
    op(8'h04, v);
    note(1, v);
    op(8'h02, v); // deliberate equal write to exercise blocking
    op(8'h01, 8'h00);
    note(2, 8'h00); note(0, v + 8'h01);
    setc('{3'h1, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1});
    for (int k = 0; k < 2; k++) begin
      op(8'h02, v - 8'h01);
      op(8'h01, 8'h00);
      op(8'h01, 8'h00);
      note(2, 8'h02); note(3, 8'h01);
      op(k == 0 ? 8'h20 : 8'h40, 8'h00);
      note(2, 8'h00);
    end
    // output preset by force in normal mode
    for (int k = 0; k < 4; k++) begin
      setc('{3'h1, 2'h0, act[k], 1'b0, 1'b1, 1'b0});
      op(8'h08, 8'h00);
      note(5, ocExp[k]); note(2, 8'h00); note(0, v + 8'h01);
    end
    setc('{3'h1, 2'h2, 2'h1, 1'b0, 1'b1, 1'b0});
    note(5, 8'h01);
    op(8'h04, 8'h03);
    op(8'h02, 8'h00);
    repeat (3) op(8'h01, 8'h00);
    note(0, 8'h03);
    op(8'h01, 8'h00);
    note(0, 8'h00); note(5, 8'h00); note(2, 8'h02);
    op(8'h40, 8'h00);
    setc('{3'h1, 2'h3, 2'h2, 1'b0, 1'b1, 1'b0});
    op(8'h08, 8'h00);
    note(5, 8'h00);
    op(8'h04, 8'h05);
    note(1, 8'h05);
    op(8'h02, 8'hFE);
    repeat (3) op(8'h01, 8'h00);
    note(0, 8'h01); note(5, 8'h01);
    repeat (6) op(8'h01, 8'h00);
    note(0, 8'h07); note(5, 8'h00);
    setc('{3'h1, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0});
    op(8'h02, 8'h10);
    op(8'h01, 8'h00);
    note(0, 8'h10);
    @(posedge mclk);
    xtalKick <= 1'b1;
    repeat (12) @(posedge mclk);
    xtalKick <= 1'b0;
    note(0, 8'h11);
    repeat (4) @(posedge mclk);
    summarize();
  end
endmodule

`default_nettype wire
